//--- include/ddl_pkg.sv
// Shared constants for the control-word latency pipeline
package ddl_pkg;

  // Pipeline ring geometry
  localparam int DDL_PTR_W = 9;
  localparam int DDL_DEPTH = 512;

  // Word widths of the three parameter paths
  localparam int DDL_FREQ_W = 32;
  localparam int DDL_PHASE_W = 16;
  localparam int DDL_AMP_W = 12;

  // Operating modes, as held in the control register
  typedef enum logic [1:0] {
    DDL_MODE_TONE  = 2'b00,
    DDL_MODE_PORT  = 2'b01,
    DDL_MODE_SWEEP = 2'b10,
    DDL_MODE_RSVD  = 2'b11
  } ddl_mode_t;

  // Path delays in ref_clk_i cycles
  localparam logic [8:0] DLY_TONE_FREQ = 9'd318;
  localparam logic [8:0] DLY_TONE_FREQ_KEY = 9'd342;
  localparam logic [8:0] DLY_TONE_PHASE = 9'd294;
  localparam logic [8:0] DLY_TONE_PHASE_KEY = 9'd318;
  localparam logic [8:0] DLY_TONE_AMP = 9'd102;
  localparam logic [8:0] DLY_TONE_AMP_MATCH = 9'd342;
  localparam logic [8:0] DLY_SWEEP_FREQ = 9'd342;
  localparam logic [8:0] DLY_SWEEP_FREQ_KEY = 9'd366;
  localparam logic [8:0] DLY_SWEEP_PHASE = 9'd318;
  localparam logic [8:0] DLY_SWEEP_PHASE_KEY = 9'd342;
  localparam logic [8:0] DLY_SWEEP_AMP = 9'd126;
  localparam logic [8:0] DLY_SWEEP_AMP_MATCH = 9'd366;

  // Register byte addresses (word aligned)
  localparam logic [7:0] REG_CTRL_ADDR = 8'h00;
  localparam logic [7:0] REG_DELAY_ADDR = 8'h04;
  localparam int REG_ADDR_W = 8;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_KEY_BIT = 2;
  localparam int CTRL_MATCH_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Delay status register fields
  localparam int STAT_FREQ_LSB = 0;
  localparam int STAT_PHASE_LSB = 10;
  localparam int STAT_AMP_LSB = 20;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY = 2'b00;

endpackage

//--- rtl/ddl_delay_line.sv
// Programmable-length delay line for one control-word path
`timescale 1ns/10ps
module ddl_delay_line
  import ddl_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int PTR_W = DDL_PTR_W,
  parameter int DEPTH = DDL_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [PTR_W-1:0] delay_i,
  input wire logic valid_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic valid_o,
  output logic [WIDTH-1:0] data_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] vld_reg, vld_next;
  logic [PTR_W-1:0] wptr_reg, wptr_next;
  logic [PTR_W-1:0] rptr;
  logic valid_reg, valid_next;
  logic [WIDTH-1:0] data_reg, data_next;

  // A slot written at edge 0 is read back at edge delay_i, because the
  // write pointer has advanced by exactly delay_i slots in between
  always_comb begin
    wptr_next = wptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
    rptr = wptr_reg - delay_i;
    vld_next = vld_reg;
    vld_next[wptr_reg] = valid_i;
    valid_next = vld_reg[rptr];
    data_next = vld_reg[rptr] ? mem[rptr] : data_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    mem[wptr_reg] <= data_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_reg <= '0;
      vld_reg <= '0;
      valid_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      vld_reg <= vld_next;
      valid_reg <= valid_next;
      data_reg <= data_next;
    end
  end

  assign valid_o = valid_reg;
  assign data_o = data_reg;

endmodule // ddl_delay_line

//--- rtl/ddl_pipeline.sv
// Latency pipeline for frequency, phase and amplitude control words
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
// How it works
// - Tone or profile mode, unmatched: frequency takes 318 cycles, or 342 with keying on.
// - Tone or profile mode, unmatched: phase takes 294 cycles (318 keyed), amplitude 102.
// - Tone or profile mode, matched: frequency and phase take 318 (342 keyed), amplitude 342.
// - Parallel-port modulation, unmatched: frequency 318/342, phase 294/318, amplitude 102.
// - Parallel-port modulation, matched: frequency and phase 318/342, amplitude 342.
// - Sweep mode, unmatched: frequency 342/366, phase 318/342, amplitude 126.
// - Sweep mode, matched: frequency and phase 342/366, amplitude 366.
module ddl_pipeline
  import ddl_pkg::*;
#(
  parameter int FREQ_W = DDL_FREQ_W,
  parameter int PHASE_W = DDL_PHASE_W,
  parameter int AMP_W = DDL_AMP_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AHB-Lite register slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic [1:0] hresp_o,
  // Parameter sources
  input wire logic freq_valid_i,
  input wire logic [FREQ_W-1:0] freq_i,
  input wire logic phase_valid_i,
  input wire logic [PHASE_W-1:0] phase_i,
  input wire logic amp_valid_i,
  input wire logic [AMP_W-1:0] amp_i,
  // Toward the phase/amplitude converter
  output logic freq_valid_o,
  output logic [FREQ_W-1:0] freq_o,
  output logic phase_valid_o,
  output logic [PHASE_W-1:0] phase_o,
  output logic amp_valid_o,
  output logic [AMP_W-1:0] amp_o
);

  // ---------------- AHB-Lite slave ----------------
  logic [3:0] ctrl_reg, ctrl_next;
  logic wr_pend_reg, wr_pend_next;
  logic [REG_ADDR_W-1:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic addr_phase;
  logic [3:0] ctrl_now;
  logic [31:0] delay_word;

  // Delay selections (registered so all paths switch on the same edge)
  logic [8:0] dly_freq_reg, dly_freq_next;
  logic [8:0] dly_phase_reg, dly_phase_next;
  logic [8:0] dly_amp_reg, dly_amp_next;

  ddl_mode_t mode;
  logic keying;
  logic matched;

  assign addr_phase = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_pend_reg && (wr_addr_reg == REG_CTRL_ADDR)) begin
      ctrl_next = hwdata_i[3:0];
    end
    // A read right after a write to the control word sees the new value
    ctrl_now = ctrl_next;
    delay_word = '0;
    delay_word[STAT_FREQ_LSB +: 9] = dly_freq_reg;
    delay_word[STAT_PHASE_LSB +: 9] = dly_phase_reg;
    delay_word[STAT_AMP_LSB +: 9] = dly_amp_reg;
    wr_pend_next = addr_phase && hwrite_i;
    wr_addr_next = addr_phase ? haddr_i[REG_ADDR_W-1:0] : wr_addr_reg;
    rdata_next = '0;
    if (addr_phase && !hwrite_i) begin
      case (haddr_i[REG_ADDR_W-1:0])
        REG_CTRL_ADDR: rdata_next = {28'h0000000, ctrl_now};
        REG_DELAY_ADDR: rdata_next = delay_word;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rdata_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Zero-wait slave: every transfer completes in its first data-phase cycle
  assign hreadyout_o = 1'b1;
  assign hresp_o = HRESP_OKAY;
  assign hrdata_o = rdata_reg;

  // ---------------- Delay selection ----------------
  assign mode = ddl_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign keying = ctrl_reg[CTRL_KEY_BIT];
  assign matched = ctrl_reg[CTRL_MATCH_BIT];

  always_comb begin
    case (mode)
      DDL_MODE_SWEEP: begin
        dly_freq_next = keying ? DLY_SWEEP_FREQ_KEY : DLY_SWEEP_FREQ;
        if (matched) begin
          dly_phase_next = dly_freq_next;
          dly_amp_next = DLY_SWEEP_AMP_MATCH;
        end else begin
          dly_phase_next = keying ? DLY_SWEEP_PHASE_KEY : DLY_SWEEP_PHASE;
          dly_amp_next = DLY_SWEEP_AMP;
        end
      end
      // Tone/profile and parallel-port share one set of figures; the
      // reserved code falls back to them rather than stalling the paths
      default: begin
        dly_freq_next = keying ? DLY_TONE_FREQ_KEY : DLY_TONE_FREQ;
        if (matched) begin
          dly_phase_next = dly_freq_next;
          dly_amp_next = DLY_TONE_AMP_MATCH;
        end else begin
          dly_phase_next = keying ? DLY_TONE_PHASE_KEY : DLY_TONE_PHASE;
          dly_amp_next = DLY_TONE_AMP;
        end
      end
    endcase
  end

  // Delays only move when the control word moves
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_freq_reg <= DLY_TONE_FREQ;
      dly_phase_reg <= DLY_TONE_PHASE;
      dly_amp_reg <= DLY_TONE_AMP;
    end else begin
      dly_freq_reg <= dly_freq_next;
      dly_phase_reg <= dly_phase_next;
      dly_amp_reg <= dly_amp_next;
    end
  end

  // ---------------- The three paths ----------------
  // Words in flight when the delay changes may be dropped or repeated;
  // software should change settings while the sources are quiet
  ddl_delay_line #(
    .WIDTH(FREQ_W)
  ) u_freq_line (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .delay_i(dly_freq_reg),
    .valid_i(freq_valid_i),
    .data_i(freq_i),
    .valid_o(freq_valid_o),
    .data_o(freq_o)
  );

  ddl_delay_line #(
    .WIDTH(PHASE_W)
  ) u_phase_line (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .delay_i(dly_phase_reg),
    .valid_i(phase_valid_i),
    .data_i(phase_i),
    .valid_o(phase_valid_o),
    .data_o(phase_o)
  );

  ddl_delay_line #(
    .WIDTH(AMP_W)
  ) u_amp_line (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .delay_i(dly_amp_reg),
    .valid_i(amp_valid_i),
    .data_i(amp_i),
    .valid_o(amp_valid_o),
    .data_o(amp_o)
  );

endmodule // ddl_pipeline

//--- tb/ddl_pipeline_monitor.sv
// Latency assertions for the control-word pipeline
`timescale 1ns/10ps
module ddl_pipeline_monitor
  import ddl_pkg::*;
#(parameter int FREQ_W = DDL_FREQ_W, parameter int AMP_W = DDL_AMP_W) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic freq_valid_i,
  input wire logic [FREQ_W-1:0] freq_i,
  input wire logic phase_valid_i,
  input wire logic amp_valid_i,
  input wire logic [AMP_W-1:0] amp_i,
  input wire logic freq_valid_o,
  input wire logic [FREQ_W-1:0] freq_o,
  input wire logic phase_valid_o,
  input wire logic amp_valid_o,
  input wire logic [AMP_W-1:0] amp_o
);
  logic wr_reg;
  logic [3:0] ctl_reg;
  logic [9:0] ctl_age;
  logic [366:0] fq_hist, ph_hist, am_hist;
  logic sw;
  // Shadow of the settings, so each latency is judged against the mode in force;
  // the age keeps a check quiet unless the settings held for the word's whole flight
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= 1'b0;
      ctl_reg <= 4'h0;
      ctl_age <= 10'h000;
      fq_hist <= '0;
      ph_hist <= '0;
      am_hist <= '0;
    end else begin
      wr_reg <= hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hwrite_i
        && haddr_i[7:0] == REG_CTRL_ADDR;
      if (wr_reg) begin
        ctl_reg <= hwdata_i[3:0];
        ctl_age <= 10'h000;
      end else if (ctl_age != 10'h3ff) begin
        ctl_age <= ctl_age + 10'h001;
      end
      // Bit k holds the entry strobe of k+1 edges ago: index D is the word whose
      // output edge was the previous one, so its strobe is visible now
      fq_hist <= {fq_hist[365:0], freq_valid_i};
      ph_hist <= {ph_hist[365:0], phase_valid_i};
      am_hist <= {am_hist[365:0], amp_valid_i};
    end
  end
  assign sw = ctl_reg[1:0] == 2'h2;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_tone_freq: assert property (fq_hist[318] && !sw && !ctl_reg[2]
    && ctl_age > 10'h13f |-> freq_valid_o)
    else $error("tone frequency latency wrong");
  chk_keyed_freq: assert property (fq_hist[342] && !sw && ctl_reg[2]
    && ctl_age > 10'h157 |-> freq_valid_o)
    else $error("keyed frequency latency wrong");
  chk_tone_phase: assert property (ph_hist[294] && !sw && ctl_reg[3:2] == 2'h0
    && ctl_age > 10'h127 |-> phase_valid_o)
    else $error("tone phase latency wrong");
  chk_port_amp: assert property (am_hist[102] && !sw && !ctl_reg[3]
    && ctl_age > 10'h067 |-> amp_valid_o && amp_o == $past(amp_i, 103))
    else $error("unmatched amplitude latency wrong");
  chk_match_amp: assert property (am_hist[342] && !sw && ctl_reg[3]
    && ctl_age > 10'h157 |-> amp_valid_o)
    else $error("matched amplitude latency wrong");
  chk_sweep_freq: assert property (fq_hist[342] && ctl_reg == 4'h2
    && ctl_age > 10'h157 |-> freq_valid_o && freq_o == $past(freq_i, 343))
    else $error("sweep frequency latency wrong");
  chk_sweep_match: assert property (ph_hist[366] && ctl_reg == 4'he
    && ctl_age > 10'h16f |-> phase_valid_o)
    else $error("sweep matched phase latency wrong");
  chk_no_stray: assert property (freq_valid_o
    |-> fq_hist[318] || fq_hist[342] || fq_hist[366])
    else $error("frequency word out of schedule");
endmodule // ddl_pipeline_monitor
bind ddl_pipeline ddl_pipeline_monitor #(.FREQ_W(FREQ_W), .AMP_W(AMP_W)) i_mon (.*);

//--- tb/ddl_conv_model.sv
// Converter-side model: stamps arrival time, count and word of each path
`timescale 1ns/10ps
module ddl_conv_model (
  input wire logic ref_clk_i,
  input wire logic [2:0] valid_i,
  input wire logic [59:0] data_i,
  output time t_o [3],
  output int n_o [3],
  output logic [59:0] word_o
);
  initial begin
    t_o = '{0, 0, 0};
    n_o = '{0, 0, 0};
    word_o = '0;
  end
  // Valid is a one-cycle pulse, so it is sampled on every edge
  always @(posedge ref_clk_i) begin
    for (int p = 0; p < 3; p++) begin
      if (valid_i[p] === 1'b1) begin
        t_o[p] = $time;
        n_o[p]++;
      end
    end
    word_o = data_i;
  end
endmodule // ddl_conv_model

//--- tb/ddl_pipeline_tb_top.sv
// Self-checking bench for the control-word latency pipeline
`timescale 1ns/10ps
module ddl_pipeline_tb_top;
  import ddl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] vi = '0;
  logic [59:0] di = '0, w2;
  wire [31:0] hrdata;
  wire [1:0] hresp;
  wire hrdy;
  wire [2:0] vo;
  wire [59:0] dout, seen;
  time t_o [3];
  time t0;
  int n_o [3], nb [3], n_fail = 0, samples_checked = 0, seed = 32'h8072;
  always #50 clk = ~clk;
  ddl_pipeline i_ddl_pipeline (.ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .freq_valid_i(vi[0]),
    .freq_i(di[31:0]), .phase_valid_i(vi[1]), .phase_i(di[47:32]), .amp_valid_i(vi[2]),
    .amp_i(di[59:48]), .freq_valid_o(vo[0]), .freq_o(dout[31:0]), .phase_valid_o(vo[1]),
    .phase_o(dout[47:32]), .amp_valid_o(vo[2]), .amp_o(dout[59:48]));
  ddl_conv_model i_ddl_conv_model (.ref_clk_i(clk), .valid_i(vo), .data_i(dout), .t_o(t_o),
    .n_o(n_o), .word_o(seen));
  function automatic int exp_dly(input logic [3:0] c, input int p);
    int b;
    b = (c[1:0] == 2'h2) ? 24 : 0;
    if (p == 0) return 318 + b + (c[2] ? 24 : 0);
    if (p == 1) return (c[3] ? 318 : 294) + b + (c[2] ? 24 : 0);
    return c[3] ? 342 + b : 102 + b;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
    chk("hresp", 64'(HRESP_OKAY), 64'(hresp));
  endtask
  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    // Everything the converter and the bus see must be quiet while reset is held
    chk("reset valid", 0, 64'(vo));
    chk("reset data", 0, 64'(dout));
    chk("reset rdata", 0, 64'(hrdata));
    rst_n <= 1'b1;
    @(posedge clk);
    // An unmapped write must leave the settings at their reset value
    bus(1'b1, 8'h08, 32'hf, rd);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk("unmapped", 0, rd);
    bus(1'b0, REG_CTRL_ADDR, 32'h0, rd);
    chk("ctrl reset", 0, rd);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, REG_CTRL_ADDR, 32'(c), rd);
      bus(1'b0, REG_CTRL_ADDR, 32'h0, rd);
      chk("ctrl", c, rd);
      bus(1'b0, REG_DELAY_ADDR, 32'h0, rd);
      chk("delay", (exp_dly(c, 2) << 20) | (exp_dly(c, 1) << 10) | exp_dly(c, 0), rd);
      repeat (3) @(posedge clk);
      t0 = $time;
      nb = n_o;
      w2 = 60'({$random(seed), $random(seed)});
      vi <= 3'h7;
      di <= 60'({$random(seed), $random(seed)});
      @(posedge clk);
      di <= w2;
      @(posedge clk);
      vi <= 3'h0;
      repeat (400) @(posedge clk);
      for (int p = 0; p < 3; p++) begin
        chk("arrivals", 2, n_o[p] - nb[p]);
        chk("latency", t0 + (exp_dly(c, p) + 3) * 100, t_o[p]);
      end
      chk("word", w2, seen);
    end
    stop_test;
  end
endmodule // ddl_pipeline_tb_top
